/* design/rwp_pkg.sv */
// Constants, register map and state encoding of the reset and watchdog control block.
// Assumes a single system clock; fuse inputs are static while the block runs.
package rwp_pkg;
	// ==========================================================
	// Register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] A_RESET_CAUSE = 8'h54;
	localparam logic [ADDR_W-1:0] A_CORE_CTRL = 8'h35;
	localparam logic [ADDR_W-1:0] A_WDT_CTRL = 8'h60;
	localparam logic [ADDR_W-1:0] A_PERIPH_GATE = 8'h64;
	// ==========================================================
	// Field positions
	localparam int CC_SLEEP_OFF = 6;
	localparam int CC_SLEEP_UNLOCK = 5;
	localparam logic [DATA_W-1:0] CC_RW_MASK = 8'h93;
	localparam int WD_CHG = 4;
	localparam int WD_EN = 3;
	localparam int WD_PS_LO = 0;
	localparam int WD_PS_W = 3;
	localparam int GT_T1 = 3;
	localparam int GT_SPI = 2;
	localparam int GT_USART = 1;
	localparam int GT_ADC = 0;
	localparam int GATE_W = 4;
	localparam int RC_JTAG = 4;
	localparam int RC_WDT = 3;
	localparam int RC_BOD = 2;
	localparam int RC_EXT = 1;
	localparam int RC_POR = 0;
	localparam int RC_W = 5;
	// ==========================================================
	// Timing in system clock cycles
	localparam logic [2:0] UNLOCK_CYC = 3'h4;
	localparam logic [2:0] SLEEP_OFF_DELAY = 3'h3;
	localparam logic [2:0] SLEEP_OFF_HOLD = 3'h3;
	// ==========================================================
	// Reset sequencer states
	typedef enum logic [1:0] {
		RS_HOLD = 2'b00,
		RS_COUNT = 2'b01,
		RS_RUN = 2'b11
	} rwp_rst_state_t;
endpackage : rwp_pkg

/* design/rwp_sysctl.sv */
// Reset source collection, release delay, brown-out sleep unlock, clock gating and watchdog.
// Assumes a CPU on the same clock driving the register port; pins are synchronised here.
//
// Our own choices: strobed register access and the address map.

module rwp_sysctl #(
	parameter int WDT_BASE = 16384,
	parameter int WDT_W = 22,
	parameter int DLY_BASE = 16,
	parameter int DLY_W = 16
) (
	// Clock and logic reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Register port
	input wire logic [rwp_pkg::ADDR_W-1:0] addr_in,
	input wire logic [rwp_pkg::DATA_W-1:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [rwp_pkg::DATA_W-1:0] rd_data_out,
	// Reset sources and detectors
	input wire logic ext_rst_n_in,
	input wire logic supply_ok_in,
	input wire logic bod_low_in,
	input wire logic jtag_rst_in,
	input wire logic wdt_osc_in,
	// Fuses
	input wire logic bod_fuse_en_in,
	input wire logic watchdog_always_on_fuse_in,
	input wire logic [1:0] startup_time_fuses_in,
	input wire logic [3:0] clock_select_fuses_in,
	// Core side
	input wire logic wdr_in,
	input wire logic comparator_bandgap_select_in,
	input wire logic adc_enable_in,
	// Outputs
	output logic core_reset_out,
	output logic port_reset_out,
	output logic gate_timer1_out,
	output logic gate_serial_periph_out,
	output logic gate_async_serial_out,
	output logic gate_converter_out,
	output logic brownout_sleep_off_out,
	output logic ref_enable_out
);
	import rwp_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0] ext_sy;
		logic [1:0] sup_sy;
		logic [1:0] bod_sy;
		logic [1:0] jtg_sy;
		logic [1:0] osc_sy;
		logic osc_d;
		rwp_rst_state_t rst_st;
		logic [DLY_W-1:0] dly_cnt;
		logic core_rst;
		logic port_rst;
		logic [DATA_W-1:0] cc;
		logic [2:0] unlock_age;
		logic [2:0] off_age;
		logic off_act;
		logic [GATE_W-1:0] gate;
		logic [RC_W-1:0] cause;
		logic watchdog_enable_bit;
		logic watchdog_change_unlock;
		logic [2:0] watchdog_change_unlock_age;
		logic [WD_PS_W-1:0] wdp;
		logic [WDT_W-1:0] wdt_cnt;
		logic wdt_pulse;
		logic ref_en;
		logic [DATA_W-1:0] rdata;
	} rwp_state_t;

	rwp_state_t st_r;
	rwp_state_t st_nxt;
	logic cc_wr;
	logic wd_wr;
	logic pg_wr;
	logic ref_cond;
	logic any_src;

	assign cc_wr = wr_in && (addr_in == A_CORE_CTRL);
	assign wd_wr = wr_in && (addr_in == A_WDT_CTRL);
	assign pg_wr = wr_in && (addr_in == A_PERIPH_GATE);
	assign ref_cond = bod_fuse_en_in || comparator_bandgap_select_in || adc_enable_in;

	// ==========================================================
	// Next state
	always_comb begin
		logic src_por;
		logic src_ext;
		logic src_bod;
		logic src_jtg;
		logic tick;
		logic [DLY_W-1:0] dly_lim;
		logic [WDT_W-1:0] wdt_lim;
		src_por = 1'b0;
		src_ext = 1'b0;
		src_bod = 1'b0;
		src_jtg = 1'b0;
		tick = 1'b0;
		dly_lim = '0;
		wdt_lim = '0;
		st_nxt = st_r;
		st_nxt.ext_sy = {st_r.ext_sy[0], ext_rst_n_in};
		st_nxt.sup_sy = {st_r.sup_sy[0], supply_ok_in};
		st_nxt.bod_sy = {st_r.bod_sy[0], bod_low_in};
		st_nxt.jtg_sy = {st_r.jtg_sy[0], jtag_rst_in};
		st_nxt.osc_sy = {st_r.osc_sy[0], wdt_osc_in};
		st_nxt.osc_d = st_r.osc_sy[1];
		tick = st_r.osc_sy[1] && !st_r.osc_d;
		src_por = !st_r.sup_sy[1];
		src_ext = !st_r.ext_sy[1];
		src_bod = bod_fuse_en_in && st_r.bod_sy[1];
		src_jtg = st_r.jtg_sy[1];
		any_src = src_por || src_ext || src_bod || src_jtg || st_r.wdt_pulse;
		st_nxt.port_rst = any_src;
		// Release delay chosen by the start-up and clock-select fuses.
		dly_lim = DLY_W'(DLY_BASE) << {startup_time_fuses_in, clock_select_fuses_in[0]};
		case (st_r.rst_st)
			RS_HOLD: begin
				st_nxt.dly_cnt = '0;
				if (!any_src) begin
					st_nxt.rst_st = RS_COUNT;
				end
			end
			RS_COUNT: begin
				if (any_src) begin
					st_nxt.rst_st = RS_HOLD;
				end else if (st_r.dly_cnt == dly_lim - DLY_W'(1)) begin
					st_nxt.rst_st = RS_RUN;
				end else begin
					st_nxt.dly_cnt = st_r.dly_cnt + DLY_W'(1);
				end
			end
			RS_RUN: begin
				if (any_src) begin
					st_nxt.rst_st = RS_HOLD;
				end
			end
			default: begin
				st_nxt.rst_st = RS_HOLD;
			end
		endcase
		st_nxt.core_rst = (st_nxt.rst_st != RS_RUN);
		// Reset cause flags: a source always wins over a software clear.
		if (wr_in && (addr_in == A_RESET_CAUSE)) begin
			st_nxt.cause = st_r.cause & wr_data_in[RC_W-1:0];
		end
		if (src_por) begin
			st_nxt.cause = '0;
			st_nxt.cause[RC_POR] = 1'b1;
		end else begin
			st_nxt.cause[RC_EXT] = st_nxt.cause[RC_EXT] | src_ext;
			st_nxt.cause[RC_BOD] = st_nxt.cause[RC_BOD] | src_bod;
			st_nxt.cause[RC_JTAG] = st_nxt.cause[RC_JTAG] | src_jtg;
			st_nxt.cause[RC_WDT] = st_nxt.cause[RC_WDT] | st_r.wdt_pulse;
		end
		if (st_r.core_rst) begin
			// I/O registers except the reset cause flags return to initial values while reset is held.
			st_nxt.cc = '0;
			st_nxt.unlock_age = '0;
			st_nxt.off_age = '0;
			st_nxt.gate = '0;
			st_nxt.watchdog_enable_bit = 1'b0;
			st_nxt.watchdog_change_unlock = 1'b0;
			st_nxt.watchdog_change_unlock_age = '0;
			st_nxt.wdp = '0;
		end else begin
			// Sleep-off unlock window.
			if (st_r.cc[CC_SLEEP_UNLOCK]) begin
				st_nxt.unlock_age = st_r.unlock_age + 3'h1;
				if (st_r.unlock_age == UNLOCK_CYC - 3'h1) begin
					st_nxt.cc[CC_SLEEP_UNLOCK] = 1'b0;
				end
			end
			if (st_r.cc[CC_SLEEP_OFF]) begin
				st_nxt.off_age = st_r.off_age + 3'h1;
				if (st_r.off_age == SLEEP_OFF_DELAY + SLEEP_OFF_HOLD - 3'h1) begin
					st_nxt.cc[CC_SLEEP_OFF] = 1'b0;
				end
			end
			if (cc_wr) begin
				st_nxt.cc = (wr_data_in & CC_RW_MASK) | (st_nxt.cc & ~CC_RW_MASK);
				if (wr_data_in[CC_SLEEP_OFF] && wr_data_in[CC_SLEEP_UNLOCK]) begin
					st_nxt.cc[CC_SLEEP_UNLOCK] = 1'b1;
					st_nxt.unlock_age = '0;
				end else if (wr_data_in[CC_SLEEP_OFF] && st_r.cc[CC_SLEEP_UNLOCK]) begin
					st_nxt.cc[CC_SLEEP_OFF] = 1'b1;
					st_nxt.cc[CC_SLEEP_UNLOCK] = 1'b0;
					st_nxt.off_age = '0;
				end
			end
			// Peripheral clock gating.
			if (pg_wr) begin
				st_nxt.gate = wr_data_in[GATE_W-1:0];
			end
			// Watchdog change-unlock window.
			if (st_r.watchdog_change_unlock) begin
				st_nxt.watchdog_change_unlock_age = st_r.watchdog_change_unlock_age + 3'h1;
				if (st_r.watchdog_change_unlock_age == UNLOCK_CYC - 3'h1) begin
					st_nxt.watchdog_change_unlock = 1'b0;
				end
			end
			if (wd_wr) begin
				if (wr_data_in[WD_CHG] && wr_data_in[WD_EN]) begin
					st_nxt.watchdog_change_unlock = 1'b1;
					st_nxt.watchdog_change_unlock_age = '0;
					st_nxt.watchdog_enable_bit = 1'b1;
				end else if (st_r.watchdog_change_unlock) begin
					st_nxt.watchdog_enable_bit = wr_data_in[WD_EN];
					st_nxt.wdp = wr_data_in[WD_PS_LO +: WD_PS_W];
					st_nxt.watchdog_change_unlock = 1'b0;
				end else if (wr_data_in[WD_EN]) begin
					st_nxt.watchdog_enable_bit = 1'b1;
				end
			end
		end
		if (watchdog_always_on_fuse_in) begin
			st_nxt.watchdog_enable_bit = 1'b1;
		end
		st_nxt.off_act = st_nxt.cc[CC_SLEEP_OFF] && (st_nxt.off_age >= SLEEP_OFF_DELAY);
		// Watchdog counter on the synchronised oscillator edge.
		wdt_lim = WDT_W'(WDT_BASE) << st_r.wdp;
		st_nxt.wdt_pulse = 1'b0;
		if (st_r.core_rst || !st_r.watchdog_enable_bit || wdr_in) begin
			st_nxt.wdt_cnt = '0;
		end else if (tick) begin
			if (st_r.wdt_cnt == wdt_lim - WDT_W'(1)) begin
				st_nxt.wdt_pulse = 1'b1;
				st_nxt.wdt_cnt = '0;
			end else begin
				st_nxt.wdt_cnt = st_r.wdt_cnt + WDT_W'(1);
			end
		end
		st_nxt.ref_en = ref_cond;
		// Read data stands only in the cycle after the read strobe.
		st_nxt.rdata = '0;
		if (rd_in) begin
			case (addr_in)
				A_RESET_CAUSE: st_nxt.rdata = DATA_W'(st_r.cause);
				A_CORE_CTRL: st_nxt.rdata = st_r.cc;
				A_WDT_CTRL: st_nxt.rdata = {3'h0, st_r.watchdog_change_unlock, st_r.watchdog_enable_bit, st_r.wdp};
				A_PERIPH_GATE: st_nxt.rdata = {4'h0, st_r.gate};
				default: st_nxt.rdata = '0;
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			st_r <= '0;
			st_r.core_rst <= 1'b1;
			st_r.port_rst <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data_out = st_r.rdata;
	assign core_reset_out = st_r.core_rst;
	assign port_reset_out = st_r.port_rst;
	assign gate_timer1_out = st_r.gate[GT_T1];
	assign gate_serial_periph_out = st_r.gate[GT_SPI];
	assign gate_async_serial_out = st_r.gate[GT_USART];
	assign gate_converter_out = st_r.gate[GT_ADC];
	assign brownout_sleep_off_out = st_r.off_act;
	assign ref_enable_out = st_r.ref_en;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_off_idle;
		!brownout_sleep_off_out [*3];
	endsequence
	sequence s_off_on;
		brownout_sleep_off_out [*3];
	endsequence

	a_off_locked: assert property (cc_wr && wr_data_in[CC_SLEEP_OFF]
		&& !wr_data_in[CC_SLEEP_UNLOCK] && !st_r.cc[CC_SLEEP_UNLOCK]
		&& !st_r.cc[CC_SLEEP_OFF] |=> !st_r.cc[CC_SLEEP_OFF])
		else $error("Sleep-off set without unlock.");
	a_off_timing: assert property ($rose(st_r.cc[CC_SLEEP_OFF])
		|-> s_off_idle ##1 s_off_on ##1 !brownout_sleep_off_out)
		else $error("Sleep-off active window wrong.");
	a_gate_reserved: assert property (rd_in && addr_in == A_PERIPH_GATE
		|=> rd_data_out[7:4] == 4'h0)
		else $error("Gating register upper bits not zero.");
	a_gate_timer: assert property (pg_wr && !st_r.core_rst
		|=> gate_timer1_out == $past(wr_data_in[GT_T1]))
		else $error("Timer1 gate did not follow write.");
	a_ref_follow: assert property (ref_cond ##1 ref_cond |=> ref_enable_out)
		else $error("Reference enable missing.");
	a_watchdog_change_unlock_clear: assert property ($rose(st_r.watchdog_change_unlock) ##0 (!wd_wr) [*4] |=> !st_r.watchdog_change_unlock)
		else $error("Change-unlock not cleared after four cycles.");
	a_wde_locked: assert property (wd_wr && !wr_data_in[WD_EN] && !st_r.watchdog_change_unlock
		&& st_r.watchdog_enable_bit && !st_r.core_rst |=> st_r.watchdog_enable_bit)
		else $error("Watchdog disabled without unlock.");
	a_wdt_pulse: assert property (st_r.wdt_pulse |=> !st_r.wdt_pulse && core_reset_out)
		else $error("Watchdog pulse not one cycle or no reset.");
	a_jtag_hold: assert property (st_r.jtg_sy[1] |=> core_reset_out)
		else $error("Scan-chain reset not holding device.");
	a_level2_on: assert property (watchdog_always_on_fuse_in ##1 watchdog_always_on_fuse_in
		|=> st_r.watchdog_enable_bit)
		else $error("Watchdog disabled at level two.");
	a_reset_delay: assert property ($fell(core_reset_out) |-> $past(st_r.rst_st) == RS_COUNT)
		else $error("Reset released before delay ran out.");
endmodule : rwp_sysctl

/* test/rwp_cpu_model.sv */
// Core-side model: issues register port cycles for the reset and watchdog block.
// Assumes one system clock; the testbench calls its tasks hierarchically.
module rwp_cpu_model (
	// Clock and read data
	input wire logic ref_clk_in,
	input wire logic [rwp_pkg::DATA_W-1:0] rd_data_in,
	// Register port
	output logic [rwp_pkg::ADDR_W-1:0] addr_out,
	output logic [rwp_pkg::DATA_W-1:0] wr_data_out,
	output logic wr_out,
	output logic rd_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import rwp_pkg::*;
	// ==========================================================
	// Bus cycles
	initial begin
		addr_out = 8'h00;
		wr_data_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// One-cycle write; a gap cycle follows so strobes never collide.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		addr_out <= a;
		wr_data_out <= d;
		wr_out <= 1'b1;
		@(posedge ref_clk_in);
		wr_out <= 1'b0;
		wr_data_out <= ~d;
	endtask : wr_reg
	// One-cycle read; data taken in the following cycle only.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge ref_clk_in);
		rd_out <= 1'b0;
		#1 d = rd_data_in;
	endtask : rd_reg
	// Unlock pair for the sleep-off bit; the sleep itself is left to the core.
	task automatic sleep_off_seq();
		wr_reg(A_CORE_CTRL, 8'h60);
		wr_reg(A_CORE_CTRL, 8'h40);
	endtask : sleep_off_seq
	// Watchdog timed change: unlock with enable, then the new value.
	task automatic wdt_change(input logic [7:0] d);
		wr_reg(A_WDT_CTRL, 8'h18);
		wr_reg(A_WDT_CTRL, d);
	endtask : wdt_change
endmodule : rwp_cpu_model

/* test/tb_rwp_sysctl.sv */
// Self-checking testbench for the reset and watchdog control block.
// Assumes the core model drives the register port; delays are shortened.
module tb_rwp_sysctl;
	timeunit 1ns;
	timeprecision 100ps;
	import rwp_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, ext_n = 1'b1, sup_ok = 1'b0, bod_low = 1'b0;
	logic jtag = 1'b0, osc = 1'b0, bod_fuse = 1'b0, bg = 1'b0, adc = 1'b0, wdr = 1'b0;
	logic wdt_fuse = 1'b0;
	logic [1:0] startup_time_fuses = 2'h0;
	logic [3:0] clock_select_fuses = 4'h0;
	logic [7:0] addr, wd, rdat, v;
	logic wr, rd, core_rst, port_rst, g_t1, g_spi, g_usart, g_adc, slp, ref_en;
	int miscompares = 0, n_compared = 0, n, k;
	// ==========================================================
	// Clocks and instances
	always #5 clk = ~clk;
	always #500 osc = ~osc;
	rwp_cpu_model cpu (.ref_clk_in(clk), .rd_data_in(rdat), .addr_out(addr),
		.wr_data_out(wd), .wr_out(wr), .rd_out(rd));
	rwp_sysctl #(.WDT_BASE(16), .DLY_BASE(2)) DUT (.ref_clk_in(clk), .nrst_in(nrst),
		.addr_in(addr), .wr_data_in(wd), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
		.ext_rst_n_in(ext_n), .supply_ok_in(sup_ok), .bod_low_in(bod_low),
		.jtag_rst_in(jtag), .wdt_osc_in(osc), .bod_fuse_en_in(bod_fuse),
		.watchdog_always_on_fuse_in(wdt_fuse), .startup_time_fuses_in(startup_time_fuses),
		.clock_select_fuses_in(clock_select_fuses), .wdr_in(wdr), .comparator_bandgap_select_in(bg),
		.adc_enable_in(adc), .core_reset_out(core_rst), .port_reset_out(port_rst),
		.gate_timer1_out(g_t1), .gate_serial_periph_out(g_spi),
		.gate_async_serial_out(g_usart), .gate_converter_out(g_adc),
		.brownout_sleep_off_out(slp), .ref_enable_out(ref_en));
	// ==========================================================
	// Helpers
	task automatic give_verdict();
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wait_core(input logic lvl, input int bound, output int cnt);
		cnt = 0;
		while (core_rst !== lvl && cnt < bound) begin
			@(posedge clk);
			#1 cnt++;
		end
		if (cnt >= bound) begin
			miscompares++;
			give_verdict();
		end
	endtask : wait_core
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
		cpu.rd_reg(a, v);
		chk(what, e, v);
	endtask : rd_chk
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		sup_ok <= 1'b1;
		wait_core(1'b0, 100, n);
		rd_chk("cause_por", A_RESET_CAUSE, 8'h01);
		rd_chk("wdt_init", A_WDT_CTRL, 8'h00);
		cpu.wr_reg(A_RESET_CAUSE, 8'h00);
		rd_chk("cause_clr", A_RESET_CAUSE, 8'h00);
		cpu.wr_reg(A_PERIPH_GATE, 8'hFF);
		rd_chk("gate_rd", A_PERIPH_GATE, 8'h0F);
		chk("gate_out", 8'h0F, {4'h0, g_t1, g_spi, g_usart, g_adc});
		cpu.wr_reg(A_PERIPH_GATE, 8'h05);
		#1 chk("gate_out2", 8'h05, {4'h0, g_t1, g_spi, g_usart, g_adc});
		cpu.wr_reg(A_CORE_CTRL, 8'h40);
		k = 0;
		repeat (12) @(posedge clk) k += slp;
		chk("sleep_nolock", 8'h00, 8'(k));
		cpu.sleep_off_seq();
		k = 0;
		repeat (12) @(posedge clk) k += slp;
		chk("sleep_len", 8'h03, 8'(k));
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{bod_fuse, bg, adc} <= 3'(i);
			repeat (3) @(posedge clk);
			chk("ref_en", 8'(i != 0), {7'h0, ref_en});
		end
		cpu.wr_reg(A_WDT_CTRL, 8'h08);
		cpu.wr_reg(A_WDT_CTRL, 8'h00);
		rd_chk("wdt_lone_clr", A_WDT_CTRL, 8'h08);
		cpu.wdt_change(8'h00);
		rd_chk("wdt_off", A_WDT_CTRL, 8'h00);
		for (int p = 0; p < 2; p++) begin
			cpu.wdt_change(8'h08 | 8'(p));
			wait_core(1'b1, 4000, n);
			chk("wdt_period", 8'h01, 8'(n >= (1600 << p) - 100 && n <= (1600 << p) + 8));
			wait_core(1'b0, 100, n);
			rd_chk("cause_wdt", A_RESET_CAUSE, 8'h08);
			rd_chk("wdt_after", A_WDT_CTRL, 8'h00);
			cpu.wr_reg(A_RESET_CAUSE, 8'h00);
		end
		bod_fuse <= 1'b1;
		startup_time_fuses <= 2'h1;
		clock_select_fuses <= 4'h1;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			ext_n <= (s != 0);
			bod_low <= (s == 1);
			jtag <= (s == 2);
			repeat (20) @(posedge clk);
			#1 chk("src_hold", 8'h03, {6'h0, core_rst, port_rst});
			@(posedge clk);
			ext_n <= 1'b1;
			bod_low <= 1'b0;
			jtag <= 1'b0;
			wait_core(1'b0, 100, n);
			chk("rel_delay", 8'(3 + (2 << 3)), 8'(n));
			chk("port_rel", 8'h00, {7'h0, port_rst});
			rd_chk("cause_src", A_RESET_CAUSE, (s == 2) ? 8'h10 : 8'h02 << s);
			rd_chk("gate_rst", A_PERIPH_GATE, 8'h00);
			cpu.wr_reg(A_RESET_CAUSE, 8'h00);
		end
		wdt_fuse <= 1'b1;
		cpu.wdt_change(8'h00);
		rd_chk("wdt_lvl2", A_WDT_CTRL, 8'h08);
		k = 0;
		for (int j = 0; j < 6; j++) begin
			repeat (500) @(posedge clk) k += core_rst;
			wdr <= 1'b1;
			@(posedge clk);
			wdr <= 1'b0;
		end
		chk("wdt_kicked", 8'h00, {7'h0, k != 0});
		wait_core(1'b1, 2000, n);
		chk("wdt_lvl2_exp", 8'h01, 8'(n >= 1500 && n <= 1610));
		wait_core(1'b0, 100, n);
		rd_chk("cause_lvl2", A_RESET_CAUSE, 8'h08);
		rd_chk("wdt_lvl2_init", A_WDT_CTRL, 8'h08);
		give_verdict();
	end
endmodule : tb_rwp_sysctl
